// ---- rtl/cse_pkg.sv ----
// package: state, exception and access-timing types for the state sequencer
package cse_pkg;

    localparam int unsigned CSE_PC_W = 24;
    localparam int unsigned CSE_FLAGS_W = 8;
    localparam int unsigned CSE_AREA_N = 8;
    localparam int unsigned CSE_AREA_W = 3;
    localparam int unsigned CSE_VEC_W = 8;

    // flags word bit positions
    localparam int unsigned CSE_GMASK_BIT = 7;
    localparam int unsigned CSE_AUX_BIT = 6;
    localparam logic [7:0] CSE_FLAGS_RST = 8'h80;

    // vector numbers
    localparam logic [7:0] CSE_VEC_RESET = 8'h00;
    localparam logic [7:0] CSE_VEC_TRAP0 = 8'h08;

    // bus cycle lengths in states
    localparam logic [1:0] CSE_ST_TWO = 2'h2;
    localparam logic [1:0] CSE_ST_THREE = 2'h3;
    localparam logic [1:0] CSE_ST_ONE = 2'h1;
    localparam logic [1:0] CSE_ST_ZERO = 2'h0;
    localparam logic [CSE_AREA_N-1:0] CSE_AREA_CFG_RST = 8'hff;

    // exception sequence step count: push pc, push flags, vector fetch
    localparam logic [1:0] CSE_STEP_PC = 2'h0;
    localparam logic [1:0] CSE_STEP_FLAGS = 2'h1;
    localparam logic [1:0] CSE_STEP_VEC = 2'h2;
    localparam logic [31:0] CSE_PUSH_BYTES = 32'h0000_0004;

    typedef enum logic [5:0] {
        CSE_RESET = 6'b000001,
        CSE_EXEC = 6'b000010,
        CSE_EXCP = 6'b000100,
        CSE_SLEEP = 6'b001000,
        CSE_SWSTBY = 6'b010000,
        CSE_HWSTBY = 6'b100000
    } cse_state_t;

    typedef enum logic [1:0] {
        CSE_SPACE_RAM = 2'b00,
        CSE_SPACE_MOD = 2'b01,
        CSE_SPACE_EXT = 2'b10
    } cse_space_t;

    // end-of-instruction report from the execution unit
    typedef struct packed {
        logic done;
        logic is_flags_op;
        logic is_trap;
        logic [1:0] trap_num;
        logic is_sleep;
    } cse_instr_t;

    // bus access request
    typedef struct packed {
        logic req;
        cse_space_t space;
        logic [CSE_AREA_W-1:0] area;
        logic word;
        logic mod_wide;
    } cse_acc_t;

endpackage : cse_pkg

// ---- rtl/cse_acc_timer.sv ----
// module: counts the states of one memory or bus cycle
module cse_acc_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire cse_pkg::cse_acc_t acc,
    input wire logic [cse_pkg::CSE_AREA_N-1:0] area_three,
    output logic busy,
    output logic done,
    output logic wide
);
    import cse_pkg::*;

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [1:0] len;
    logic start;

    // on-chip memory two states, modules three, external per area
    assign len = (acc.space == CSE_SPACE_RAM) ? CSE_ST_TWO :
                 (acc.space == CSE_SPACE_MOD) ? CSE_ST_THREE :
                 (area_three[acc.area] ? CSE_ST_THREE : CSE_ST_TWO);
    assign start = acc.req && (cnt_q == CSE_ST_ZERO);
    assign cnt_d = start ? len - CSE_ST_ONE :
                   (cnt_q != CSE_ST_ZERO) ? cnt_q - CSE_ST_ONE : cnt_q;
    assign busy = start || (cnt_q != CSE_ST_ZERO);
    assign done = (cnt_q == CSE_ST_ONE);
    // on-chip memory is 16 bit; modules by register width
    assign wide = (acc.space == CSE_SPACE_RAM) ? 1'b1 :
                  (acc.space == CSE_SPACE_MOD) ? acc.mod_wide : acc.word;

    // state counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= CSE_ST_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : cse_acc_timer

// ---- rtl/cse_state_seq.sv ----
// module: processing-state and exception sequencer of the cpu core
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module cse_state_seq (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CHIP_INIT_PIN_B,
    input wire logic HALT_REQUEST_PIN_B,
    input wire logic WDT_OVF,
    input wire logic IRQ_REQ,
    input wire logic [cse_pkg::CSE_VEC_W-1:0] IRQ_VEC,
    input wire logic NMI_REQ,
    input wire cse_pkg::cse_instr_t INSTR,
    input wire logic [cse_pkg::CSE_PC_W-1:0] PC_NEXT,
    input wire logic [cse_pkg::CSE_FLAGS_W-1:0] FLAGS_IN,
    input wire logic FLAGS_WE,
    input wire logic [31:0] SP_IN,
    input wire logic DEEP_SLEEP_SELECT,
    input wire logic USER_FLAG_ENABLE_WR,
    input wire logic USER_FLAG_ENABLE_WE,
    input wire logic [cse_pkg::CSE_AREA_N-1:0] AREA_THREE_STATE,
    input wire cse_pkg::cse_acc_t ACC,
    input wire logic [15:0] PORT_IN,
    input wire logic WAKE,
    output logic [5:0] STATE,
    output logic [cse_pkg::CSE_FLAGS_W-1:0] FLAGS_WORD,
    output logic USER_FLAG_ENABLE,
    output logic PUSH_VALID,
    output logic [31:0] PUSH_ADDR,
    output logic [31:0] PUSH_DATA,
    output logic VEC_FETCH,
    output logic [cse_pkg::CSE_VEC_W-1:0] VEC_NUM,
    output logic IRQ_ACK,
    output logic CPU_RUN,
    output logic CLOCK_RUN,
    output logic MODULE_RST_B,
    output logic [15:0] PORT_HOLD,
    output logic PORT_HOLD_EN,
    output logic ACC_BUSY,
    output logic ACC_DONE,
    output logic ACC_WIDE
);
    import cse_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic init_m_q, init_s_q, init_p_q;
    logic halt_m_q, halt_s_q;

    // two flops per pin before any logic reads them
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            init_m_q <= 1'b0;
            init_s_q <= 1'b0;
            init_p_q <= 1'b0;
            halt_m_q <= 1'b1;
            halt_s_q <= 1'b1;
        end else begin
            init_m_q <= CHIP_INIT_PIN_B;
            init_s_q <= init_m_q;
            init_p_q <= init_s_q;
            halt_m_q <= HALT_REQUEST_PIN_B;
            halt_s_q <= halt_m_q;
        end
    end

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    cse_state_t state_q, state_d;
    logic [CSE_FLAGS_W-1:0] flags_q, flags_d;
    logic ufe_q, ufe_d;
    logic [1:0] step_q, step_d;
    logic [CSE_VEC_W-1:0] vec_q, vec_d;
    logic irq_block_q, irq_block_d;
    logic [31:0] sp_q, sp_d;
    logic push_q, vecf_q, ack_q;
    logic [31:0] paddr_q, pdata_q;
    logic [15:0] hold_q;
    logic hold_en_q;
    logic acc_busy, acc_done, acc_wide;
    logic acc_busy_q, acc_done_q, acc_wide_q;

    logic init_low, init_rise, halt_low;
    logic instr_end, irq_ok, trap_go, sleep_go;
    logic take_irq, take_nmi;
    logic [CSE_FLAGS_W-1:0] mask_set;

    // reset is seen only through the clocked synchroniser
    assign init_low = !init_s_q;
    assign init_rise = init_s_q && !init_p_q;
    assign halt_low = !halt_s_q;
    assign instr_end = (state_q == CSE_EXEC) && INSTR.done;
    // flags-word instructions close the window for one instruction
    // blocked through reset handling and its first instruction
    assign irq_ok = instr_end && !INSTR.is_flags_op && !irq_block_q;
    // interrupts sampled only at instruction end
    assign take_nmi = irq_ok && NMI_REQ;
    assign take_irq = irq_ok && IRQ_REQ;
    assign trap_go = instr_end && INSTR.is_trap && !take_nmi && !take_irq;
    assign sleep_go = instr_end && INSTR.is_sleep && !INSTR.is_trap &&
                      !take_nmi && !take_irq;
    // global mask; aux mask too when enable is clear
    assign mask_set = ufe_q ? (CSE_FLAGS_W'(1) << CSE_GMASK_BIT) :
                      ((CSE_FLAGS_W'(1) << CSE_GMASK_BIT) |
                       (CSE_FLAGS_W'(1) << CSE_AUX_BIT));

    // ----------------------------------------------------------------
    // state machine next value
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        flags_d = FLAGS_WE ? FLAGS_IN : flags_q;
        ufe_d = USER_FLAG_ENABLE_WE ? USER_FLAG_ENABLE_WR : ufe_q;
        step_d = step_q;
        vec_d = vec_q;
        irq_block_d = irq_block_q && !instr_end;
        sp_d = SP_IN;
        // init or watchdog aborts everything; leaving
        // hardware standby takes the same reset entry
        if (init_low || WDT_OVF || (state_q == CSE_HWSTBY && !halt_low)) begin
            state_d = CSE_RESET;
            flags_d = flags_q | (CSE_FLAGS_W'(1) << CSE_GMASK_BIT);
            ufe_d = 1'b1;
            irq_block_d = 1'b1;
        end else begin
            unique case (state_q)
                CSE_RESET: begin
                    // synchronised init pin high, edge or level, starts the reset vector fetch
                    if (init_rise || init_s_q) begin
                        state_d = CSE_EXCP;
                        step_d = CSE_STEP_VEC;
                        vec_d = CSE_VEC_RESET;
                    end
                end
                CSE_EXEC: begin
                    if (halt_low) begin
                        state_d = CSE_HWSTBY;
                    end else if (take_nmi || take_irq || trap_go) begin
                        state_d = CSE_EXCP;
                        step_d = CSE_STEP_PC;
                        vec_d = trap_go ?
                                CSE_VEC_TRAP0 + CSE_VEC_W'(INSTR.trap_num) :
                                IRQ_VEC;
                    end else if (sleep_go) begin
                        state_d = DEEP_SLEEP_SELECT ? CSE_SWSTBY : CSE_SLEEP;
                    end
                end
                CSE_EXCP: begin
                    // push pc, push flags, then vector
                    unique case (step_q)
                        CSE_STEP_PC: step_d = CSE_STEP_FLAGS;
                        CSE_STEP_FLAGS: begin
                            step_d = CSE_STEP_VEC;
                            flags_d = flags_q | mask_set;
                        end
                        default: state_d = CSE_EXEC;
                    endcase
                end
                CSE_SLEEP, CSE_SWSTBY: begin
                    if (halt_low) begin
                        state_d = CSE_HWSTBY;
                    end else if (WAKE) begin
                        state_d = CSE_EXEC;
                    end
                end
                // held here; the pin release takes the reset entry above
                CSE_HWSTBY: state_d = CSE_HWSTBY;
                default: state_d = CSE_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= CSE_RESET;
            flags_q <= CSE_FLAGS_RST;
            ufe_q <= 1'b1;
            step_q <= CSE_STEP_PC;
            vec_q <= CSE_VEC_RESET;
            irq_block_q <= 1'b1;
            sp_q <= '0;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            ufe_q <= ufe_d;
            step_q <= step_d;
            vec_q <= vec_d;
            irq_block_q <= irq_block_d;
            sp_q <= sp_d;
        end
    end

    // ----------------------------------------------------------------
    // stack push and vector strobes
    // ----------------------------------------------------------------
    logic push_d, vecf_d, ack_d;
    logic [31:0] paddr_d, pdata_d;
    logic excp_live;

    // an abort in the same cycle cancels the strobe
    assign excp_live = (state_q == CSE_EXCP) && !init_low && !WDT_OVF;
    // pc first at sp-4, then flags at sp-8
    assign push_d = excp_live && (step_q != CSE_STEP_VEC);
    assign paddr_d = (step_q == CSE_STEP_PC) ? sp_q - CSE_PUSH_BYTES :
                     sp_q - (CSE_PUSH_BYTES << 1);
    assign pdata_d = (step_q == CSE_STEP_PC) ?
                     {{(32 - CSE_PC_W){1'b0}}, PC_NEXT} :
                     {{(32 - CSE_FLAGS_W){1'b0}}, flags_q};
    // vector fetch only in the last step
    assign vecf_d = excp_live && (step_q == CSE_STEP_VEC);
    assign ack_d = (state_q == CSE_EXEC) && (take_nmi || take_irq) &&
                   !init_low && !WDT_OVF && !halt_low;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            push_q <= 1'b0;
            paddr_q <= '0;
            pdata_q <= '0;
            vecf_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            push_q <= push_d;
            paddr_q <= paddr_d;
            pdata_q <= pdata_d;
            vecf_q <= vecf_d;
            ack_q <= ack_d;
        end
    end

    // ----------------------------------------------------------------
    // power-down pin hold
    // ----------------------------------------------------------------
    logic run_q, crun_q, mrst_b_q;
    // capture ports on entry and hold them in software standby
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            hold_q <= '0;
            hold_en_q <= 1'b0;
            run_q <= 1'b0;
            crun_q <= 1'b1;
            mrst_b_q <= 1'b0;
        end else begin
            if (state_q != CSE_SWSTBY) begin
                hold_q <= PORT_IN;
            end
            hold_en_q <= (state_d == CSE_SWSTBY);
            // run levels follow the next state
            run_q <= (state_d == CSE_EXEC) || (state_d == CSE_EXCP);
            crun_q <= !(state_d inside {CSE_SWSTBY, CSE_HWSTBY});
            mrst_b_q <= !(state_d inside {CSE_SWSTBY, CSE_HWSTBY, CSE_RESET});
        end
    end

    // ----------------------------------------------------------------
    // access timing
    // ----------------------------------------------------------------
    // state counting per access
    cse_acc_timer u_timer (
        .clk(CLOCK),
        .rst_b(RST_B),
        .acc(ACC),
        .area_three(AREA_THREE_STATE),
        .busy(acc_busy),
        .done(acc_done),
        .wide(acc_wide)
    );

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            acc_busy_q <= 1'b0;
            acc_done_q <= 1'b0;
            acc_wide_q <= 1'b0;
        end else begin
            acc_busy_q <= acc_busy;
            acc_done_q <= acc_done;
            acc_wide_q <= acc_wide;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flops
    // ----------------------------------------------------------------
    assign STATE = state_q;
    assign FLAGS_WORD = flags_q;
    assign USER_FLAG_ENABLE = ufe_q;
    assign PUSH_VALID = push_q;
    assign PUSH_ADDR = paddr_q;
    assign PUSH_DATA = pdata_q;
    assign VEC_FETCH = vecf_q;
    assign VEC_NUM = vec_q;
    assign IRQ_ACK = ack_q;
    assign CPU_RUN = run_q;
    assign CLOCK_RUN = crun_q;
    assign MODULE_RST_B = mrst_b_q;
    assign PORT_HOLD = hold_q;
    assign PORT_HOLD_EN = hold_en_q;
    assign ACC_BUSY = acc_busy_q;
    assign ACC_DONE = acc_done_q;
    assign ACC_WIDE = acc_wide_q;

endmodule : cse_state_seq

// ---- sim/cse_irq_model.sv ----
// model: interrupt controller on the far side of the sequencer
module cse_irq_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raise,
    input wire logic nmi,
    input wire logic [7:0] vec,
    input wire logic ack,
    output logic irq_req,
    output logic nmi_req,
    output logic [7:0] irq_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    // request level stays up until the core acknowledges it; a released
    // vector is inverted so a stale value can never pass for a live one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
            nmi_req <= 1'b0;
            irq_vec <= 8'h00;
        end else if (raise) begin
            irq_req <= !nmi;
            nmi_req <= nmi;
            irq_vec <= vec;
        end else if (ack) begin
            irq_req <= 1'b0;
            nmi_req <= 1'b0;
            irq_vec <= ~irq_vec;
        end
    end
endmodule : cse_irq_model

// ---- sim/cse_state_seq_asserts.sv ----
// checker: port timing relations of the state sequencer
module cse_state_seq_asserts (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CHIP_INIT_PIN_B,
    input wire logic HALT_REQUEST_PIN_B,
    input wire logic WDT_OVF,
    input wire logic IRQ_REQ,
    input wire logic NMI_REQ,
    input wire cse_pkg::cse_instr_t INSTR,
    input wire logic DEEP_SLEEP_SELECT,
    input wire cse_pkg::cse_acc_t ACC,
    input wire logic [5:0] STATE,
    input wire logic [7:0] FLAGS_WORD,
    input wire logic USER_FLAG_ENABLE,
    input wire logic PUSH_VALID,
    input wire logic VEC_FETCH,
    input wire logic [7:0] VEC_NUM,
    input wire logic IRQ_ACK,
    input wire logic CPU_RUN,
    input wire logic CLOCK_RUN,
    input wire logic MODULE_RST_B,
    input wire logic [15:0] PORT_HOLD,
    input wire logic PORT_HOLD_EN,
    input wire logic ACC_BUSY,
    input wire logic ACC_DONE
);
    import cse_pkg::*;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // ------------------------------------------------
    // first instruction window after a reset
    // ------------------------------------------------
    logic first_q;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            first_q <= 1'b1;
        end else if (STATE == CSE_RESET) begin
            first_q <= 1'b1;
        end else if (INSTR.done && STATE == CSE_EXEC) begin
            first_q <= 1'b0;
        end
    end
    chk_init_abort: assert property (
        !CHIP_INIT_PIN_B |-> ##[1:3] STATE == CSE_RESET)
        else $error("init pin did not reach reset");
    chk_wdt_reset: assert property (
        WDT_OVF |=> STATE == CSE_RESET)
        else $error("watchdog overflow did not reset");
    chk_reset_mask: assert property (
        STATE == CSE_RESET |-> FLAGS_WORD[7])
        else $error("global mask clear in reset");
    chk_irq_taken: assert property (
        IRQ_ACK |-> $past(INSTR.done) && $past(STATE) == CSE_EXEC
            && !$past(INSTR.is_flags_op))
        else $error("interrupt taken at wrong point");
    chk_no_irq_boot: assert property (
        first_q |=> !IRQ_ACK)
        else $error("interrupt taken right after reset");
    // stack then vector; an init pull stops the sequence
    chk_stack_seq: assert property (
        disable iff (!RST_B || !CHIP_INIT_PIN_B)
        $rose(STATE == CSE_EXCP) && $past(STATE) == CSE_EXEC |=>
        PUSH_VALID && !VEC_FETCH ##1 PUSH_VALID && !VEC_FETCH
        ##1 VEC_FETCH && !PUSH_VALID)
        else $error("stacking or vector order wrong");
    chk_mask_set: assert property (
        PUSH_VALID && $past(PUSH_VALID) |=> FLAGS_WORD[7]
            && (USER_FLAG_ENABLE || FLAGS_WORD[6]))
        else $error("mask flags not set");
    chk_reset_vec: assert property (
        STATE == CSE_EXCP && $past(STATE) == CSE_RESET |=>
        VEC_FETCH && VEC_NUM == CSE_VEC_RESET && !PUSH_VALID)
        else $error("reset vector fetch wrong");
    chk_sleep_enter: assert property (
        INSTR.done && INSTR.is_sleep && !INSTR.is_trap && !IRQ_REQ
            && !NMI_REQ && STATE == CSE_EXEC |=>
        STATE == ($past(DEEP_SLEEP_SELECT) ? CSE_SWSTBY : CSE_SLEEP))
        else $error("sleep entry state wrong");
    chk_standby_out: assert property (
        STATE == CSE_SWSTBY && $past(STATE) == CSE_SWSTBY |->
        !CPU_RUN && !CLOCK_RUN && !MODULE_RST_B && PORT_HOLD_EN
            && $stable(PORT_HOLD))
        else $error("standby outputs wrong");
    chk_halt_enter: assert property (
        !HALT_REQUEST_PIN_B |-> ##[1:3] STATE == CSE_HWSTBY
            && !CLOCK_RUN && !MODULE_RST_B)
        else $error("halt pin did not stop the core");
    chk_ram_access: assert property (
        ACC.req && !ACC_BUSY && ACC.space == CSE_SPACE_RAM
            |-> ##[2:3] ACC_DONE)
        else $error("memory access too long");
endmodule : cse_state_seq_asserts

// ---- sim/cse_state_seq_tb.sv ----
// testbench: self-checking bench of the state sequencer
module cse_state_seq_tb;
    import cse_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, init_b = 1'b0, halt_b = 1'b1;
    logic wdt = 1'b0, raise = 1'b0, rnmi = 1'b0, fwe = 1'b0, uew = 1'b1;
    logic uewe = 1'b0, dss = 1'b0, wake = 1'b0, uem = 1'b1;
    logic [7:0] rvec = 8'h80, fin = 8'h00, fm = CSE_FLAGS_RST, a3 = 8'h00;
    logic [15:0] pin = 16'h0000, hold, ph;
    logic [23:0] pc = 24'h00_0000;
    logic [31:0] sp = 32'h0000_1000, seed = 32'h0001_47D2, pa, pd;
    cse_instr_t ins = '0;
    cse_acc_t acc = '0;
    logic irq, nmi, pv, vf, ack, run, crun, mrst_b, phe, abusy, adone;
    logic awide, ue;
    logic [7:0] ivec, fw, vn;
    logic [5:0] st;
    logic [2:0] ar;
    int miscompares = 0, tests_run = 0, base, n;
    // ------------------------------------------------
    // clock, design and far-side model
    // ------------------------------------------------
    always #2 clk = ~clk;
    cse_state_seq dut (
        .CLOCK(clk), .RST_B(rst_b), .CHIP_INIT_PIN_B(init_b),
        .HALT_REQUEST_PIN_B(halt_b), .WDT_OVF(wdt), .IRQ_REQ(irq),
        .IRQ_VEC(ivec), .NMI_REQ(nmi), .INSTR(ins), .PC_NEXT(pc),
        .FLAGS_IN(fin), .FLAGS_WE(fwe), .SP_IN(sp),
        .DEEP_SLEEP_SELECT(dss), .USER_FLAG_ENABLE_WR(uew),
        .USER_FLAG_ENABLE_WE(uewe), .AREA_THREE_STATE(a3), .ACC(acc),
        .PORT_IN(pin), .WAKE(wake), .STATE(st), .FLAGS_WORD(fw),
        .USER_FLAG_ENABLE(ue), .PUSH_VALID(pv), .PUSH_ADDR(pa),
        .PUSH_DATA(pd), .VEC_FETCH(vf), .VEC_NUM(vn), .IRQ_ACK(ack),
        .CPU_RUN(run), .CLOCK_RUN(crun), .MODULE_RST_B(mrst_b),
        .PORT_HOLD(ph), .PORT_HOLD_EN(phe), .ACC_BUSY(abusy),
        .ACC_DONE(adone), .ACC_WIDE(awide));
    cse_irq_model irqc (.clk(clk), .rst_b(rst_b), .raise(raise),
        .nmi(rnmi), .vec(rvec), .ack(ack), .irq_req(irq), .nmi_req(nmi),
        .irq_vec(ivec));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] exp_flags(input logic [7:0] f,
                                             input logic u);
        return f | 8'h80 | (u ? 8'h00 : 8'h40);
    endfunction : exp_flags
    function automatic int exp_len(input cse_acc_t a);
        if (a.space == CSE_SPACE_RAM) return 2;
        if (a.space == CSE_SPACE_MOD) return 3;
        return a3[a.area] ? 3 : 2;
    endfunction : exp_len
    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic wait_for(input logic [5:0] s);
        int k = 0;
        while (st !== s && k < 40) begin
            tick(1);
            k++;
        end
        check("state", 32'(st), 32'(s));
    endtask : wait_for
    task automatic instr(input logic fo, input logic tr,
                         input logic [1:0] tn, input logic sl);
        ins = '{1'b1, fo, tr, tn, sl};
        tick(1);
        ins = '0;
    endtask : instr
    task automatic setup(input logic u);
        uew = u;
        uewe = 1'b1;
        fin = 8'(rnd());
        fwe = 1'b1;
        sp = rnd() & 32'hFFFF_FFFC;
        pc = 24'(rnd());
        tick(1);
        uewe = 1'b0;
        fwe = 1'b0;
        uem = u;
        fm = fin;
    endtask : setup
    task automatic raise_irq(input logic m);
        rvec = {1'b1, 7'(rnd())};
        rnmi = m;
        raise = 1'b1;
        tick(1);
        raise = 1'b0;
    endtask : raise_irq
    // entered in the cycle after the taken instruction end
    task automatic take(input logic k, input logic [7:0] v);
        check("state", 32'(st), 32'(CSE_EXCP));
        check("ack", 32'(ack), 32'(k));
        tick(1);
        check("pc addr", pa, sp - 32'h0000_0004);
        check("pc data", pd, {8'h00, pc});
        tick(1);
        check("flag addr", pa, sp - 32'h0000_0008);
        check("flag data", pd, {24'h00_0000, fm});
        tick(1);
        check("vector", {23'h0, vf, vn}, {23'h0, 1'b1, v});
        fm = exp_flags(fm, uem);
        check("flags", 32'(fw), 32'(fm));
        wait_for(CSE_EXEC);
    endtask : take
    // reset exception, refused first end, then a taken request
    task automatic boot();
        int k = 0;
        while (vf !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        check("reset fetch", 32'({vf, vn}), 32'h0000_0100);
        wait_for(CSE_EXEC);
        check("enable", 32'(ue), 32'h0000_0001);
        setup(1'b1);
        raise_irq(1'b0);
        instr(1'b0, 1'b0, 2'h0, 1'b0);
        check("boot ack", 32'({ack, st}), 32'({1'b0, CSE_EXEC}));
        instr(1'b0, 1'b0, 2'h0, 1'b0);
        take(1'b1, rvec);
    endtask : boot
    task automatic access(input cse_acc_t a, output int c);
        acc = '{1'b1, a.space, a.area, a.word, a.mod_wide};
        tick(1);
        acc.req = 1'b0;
        c = 0;
        while (adone !== 1'b1 && c < 10) begin
            tick(1);
            c++;
        end
        check("busy wide", 32'({abusy, awide}), 32'({1'b1,
              a.space == CSE_SPACE_RAM || (a.space == CSE_SPACE_MOD ?
              a.mod_wide : a.word)}));
        tick(2);
    endtask : access
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        tick(12);
        check("reset", 32'({st, fw, ue, mrst_b}), 32'h0000_0602);
        rst_b = 1'b1;
        tick(3);
        init_b = 1'b1;
        boot();
        // traps of every number, interrupts beating traps, flags ops
        for (int i = 0; i < 16; i++) begin
            logic k;
            k = i[0] && i[2];
            setup(i[0]);
            if (k) begin
                raise_irq(i[3]);
                instr(1'b1, 1'b0, 2'h0, 1'b0);
                check("flags op", 32'({ack, st}), 32'(CSE_EXEC));
            end
            instr(1'b0, i[1], 2'(i[3:2]), 1'b0);
            if (k || i[1]) begin
                take(k, k ? rvec : CSE_VEC_TRAP0 + 8'(i[3:2]));
            end else begin
                check("plain", 32'({ack, st}), 32'(CSE_EXEC));
            end
        end
        for (int d = 0; d < 2; d++) begin
            dss = d[0];
            pin = 16'(rnd());
            instr(1'b0, 1'b0, 2'h0, 1'b1);
            check("sleep", 32'(st), 32'(d ? CSE_SWSTBY : CSE_SLEEP));
            check("run", 32'({run, crun, mrst_b}), d ? 32'h0 : 32'h3);
            hold = pin;
            pin = ~pin;
            tick(2);
            if (d) check("hold", 32'({phe, ph}), 32'({1'b1, hold}));
            wake = 1'b1;
            wait_for(CSE_EXEC);
            wake = 1'b0;
        end
        halt_b = 1'b0;
        wait_for(CSE_HWSTBY);
        halt_b = 1'b1;
        boot();
        wdt = 1'b1;
        tick(1);
        wdt = 1'b0;
        check("watchdog", 32'(st), 32'(CSE_RESET));
        boot();
        // init pin pulled in the middle of a trap sequence
        instr(1'b0, 1'b1, 2'h0, 1'b0);
        init_b = 1'b0;
        wait_for(CSE_RESET);
        tick(3);
        init_b = 1'b1;
        boot();
        access('{1'b1, CSE_SPACE_RAM, 3'h0, 1'b1, 1'b0}, base);
        for (int k = 0; k < 12; k++) begin
            a3 = 8'(rnd());
            ar = 3'(rnd());
            access('{1'b1, cse_space_t'(k % 3), ar, k[2], k[1]}, n);
            check("length", 32'(n - base),
                  32'(exp_len(cse_acc_t'({1'b1, 2'(k % 3), ar, 2'h0})) - 2));
        end
        report_and_stop();
    end
    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule : cse_state_seq_tb
bind cse_state_seq cse_state_seq_asserts chk (.CLOCK(CLOCK),
    .RST_B(RST_B), .CHIP_INIT_PIN_B(CHIP_INIT_PIN_B),
    .HALT_REQUEST_PIN_B(HALT_REQUEST_PIN_B), .WDT_OVF(WDT_OVF),
    .IRQ_REQ(IRQ_REQ), .NMI_REQ(NMI_REQ), .INSTR(INSTR),
    .DEEP_SLEEP_SELECT(DEEP_SLEEP_SELECT), .ACC(ACC), .STATE(STATE),
    .FLAGS_WORD(FLAGS_WORD), .USER_FLAG_ENABLE(USER_FLAG_ENABLE),
    .PUSH_VALID(PUSH_VALID), .VEC_FETCH(VEC_FETCH), .VEC_NUM(VEC_NUM),
    .IRQ_ACK(IRQ_ACK), .CPU_RUN(CPU_RUN), .CLOCK_RUN(CLOCK_RUN),
    .MODULE_RST_B(MODULE_RST_B), .PORT_HOLD(PORT_HOLD),
    .PORT_HOLD_EN(PORT_HOLD_EN), .ACC_BUSY(ACC_BUSY), .ACC_DONE(ACC_DONE));
